// >>> dv/host_bridge_model.sv
`default_nettype none
module host_bridge_model (
    // Clock and read data
    input wire logic i_clk,
    input wire logic [15:0] i_cfg_rdata,
    // Configuration strobes
    output logic o_cfg_rd,
    output logic o_cfg_wr,
    output logic [7:0] o_cfg_addr,
    output logic [15:0] o_cfg_wdata,
    // Bus reset and isolation
    output logic o_bus_rst_n,
    output logic o_isolate_n
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_cfg_rd = 1'b0;
        o_cfg_wr = 1'b0;
        o_cfg_addr = 8'h00;
        o_cfg_wdata = 16'h0000;
        o_bus_rst_n = 1'b1;
        o_isolate_n = 1'b1;
    end
    // one-word config cycle
    // Idle lines inverted so stale values never match
    task automatic cfg(input logic wr, input logic [7:0] a,
                       input logic [15:0] d, output logic [15:0] q);
        @(posedge i_clk);
        o_cfg_wr <= wr;
        o_cfg_rd <= ~wr;
        o_cfg_addr <= a;
        o_cfg_wdata <= d;
        @(posedge i_clk);
        o_cfg_wr <= 1'b0;
        o_cfg_rd <= 1'b0;
        o_cfg_addr <= ~a;
        o_cfg_wdata <= ~d;
        @(posedge i_clk);
        #1;
        q = i_cfg_rdata;
    endtask : cfg
    task automatic pins(input logic rst_n, input logic iso_n);
        @(posedge i_clk);
        o_bus_rst_n <= rst_n;
        o_isolate_n <= iso_n;
    endtask : pins
endmodule : host_bridge_model
`default_nettype wire

// >>> dv/pm_ctrl_tb.sv
`default_nettype none
module pm_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pm_pkg::*;
    localparam int IDLE = 4;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic alt_n = 1'b1;
    logic aux = 1'b0;
    logic link = 1'b1;
    logic wake = 1'b0;
    logic busy = 1'b1;
    logic cfg_rd, cfg_wr, bus_rst_n, isolate_n, strap, en;
    logic [7:0] cfg_addr;
    logic [15:0] cfg_wdata, dout, rdata, q;
    logic master_en, target_en, cfg_en, irq_en, bus_out_en, wol_en;
    logic link_alive, deep_pd, standby, init, pme_oe, cstschg;
    pm_state_type state;
    logic [7:0] bars [3] = '{BAR_CTRL_OFS, BAR_IO_OFS, BAR_MEM_OFS};
    int mismatches = 0;
    int checked = 0;
    // 20 ns period, well above the bus clock floor
    always #10 clk = ~clk;
    pm_ctrl #(.IDLE_CYCLES(IDLE)) u_dut (
        .i_clk(clk), .i_sys_rst(sys_rst),
        .i_alternate_por_input_n(alt_n), .i_bus_rst_n(bus_rst_n),
        .i_isolate_n(isolate_n), .i_aux_supply_sense(aux),
        .i_cfg_rd(cfg_rd), .i_cfg_wr(cfg_wr), .i_cfg_addr(cfg_addr),
        .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(dout),
        .i_link_valid(link), .i_wake_pkt(wake), .i_dev_busy(busy),
        .o_master_en(master_en), .o_target_en(target_en),
        .o_cfg_en(cfg_en), .o_irq_en(irq_en), .o_bus_out_en(bus_out_en),
        .o_wol_en(wol_en), .o_link_alive(link_alive),
        .o_deep_pd(deep_pd), .o_standby(standby), .o_init(init),
        .o_pm_state(state), .o_pme_n_oe(pme_oe), .o_cstschg(cstschg));
    host_bridge_model u_host (
        .i_clk(clk), .i_cfg_rdata(dout), .o_cfg_rd(cfg_rd),
        .o_cfg_wr(cfg_wr), .o_cfg_addr(cfg_addr), .o_cfg_wdata(cfg_wdata),
        .o_bus_rst_n(bus_rst_n), .o_isolate_n(isolate_n));
    // ----------------------------------------
    // Expectations and checks
    // ----------------------------------------
    function automatic logic [15:0] exp_cap(input logic a);
        exp_cap = PM_CAP_BASE;
        exp_cap[PM_CAP_AUX_BIT] = a;
    endfunction : exp_cap
    function automatic logic [15:0] pmcsr(input logic [1:0] s,
                                          input logic e, input logic c);
        pmcsr = 16'h0000;
        pmcsr[PMCSR_STATE_LSB +: 2] = s;
        pmcsr[PMCSR_PME_EN_BIT] = e;
        pmcsr[PMCSR_PME_STS_BIT] = c;
    endfunction : pmcsr
    task automatic tally_and_finish();
        if (mismatches == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t bit %b exp %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t word %h exp %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_state(input pm_state_type got,
                             input pm_state_type exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t state %0d exp %0d", $time, got, exp);
        end
    endtask : chk_state
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_host.cfg(1'b1, a, d, q);
        tick(1);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        u_host.cfg(1'b0, a, 16'h0000, rdata);
    endtask : rd
    task automatic pulse_wake();
        @(posedge clk);
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        tick(2);
    endtask : pulse_wake
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        void'($urandom(70));
        strap = 1'($urandom);
        aux = strap;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        tick(5);
        chk_state(state, d0_uninitialized);
        chk_bit(master_en, 1'b0);
        chk_bit(target_en, 1'b1);
        chk_bit(wol_en, 1'b1);
        @(posedge clk);
        aux <= ~strap;
        rd(PM_CAP_OFS);
        chk_word(rdata, exp_cap(strap));
        rd(8'h40);
        chk_word(rdata, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            u_host.pins(1'b0, 1'b1);
            tick(2);
            chk_bit(init, 1'b1);
            u_host.pins(1'b1, 1'b1);
            tick(3);
            chk_state(state, d0_uninitialized);
            wr(bars[i], 16'($urandom));
            chk_state(state, d0_active_state);
            chk_bit(master_en, 1'b1);
            chk_bit(irq_en, 1'b1);
            chk_bit(wol_en, 1'b0);
        end
        @(posedge clk);
        busy <= 1'b0;
        tick(IDLE + 3);
        chk_bit(standby, 1'b1);
        @(posedge clk);
        busy <= 1'b1;
        tick(2);
        chk_bit(standby, 1'b0);
        for (int i = 1; i < 4; i++) begin
            en = (i == 3) ? 1'($urandom) : 1'b1;
            wr(PMCSR_OFS, pmcsr(2'(i), en, 1'b0));
            chk_state(state, pm_state_type'(3'(i + 1)));
            rd(PMCSR_OFS);
            chk_word(rdata, pmcsr(2'(i), en, 1'b0));
            chk_bit(master_en, 1'b0);
            chk_bit(irq_en, 1'b0);
            chk_bit(cfg_en, 1'b1);
            chk_bit(link_alive, en);
            pulse_wake();
            chk_bit(pme_oe, en);
            chk_bit(cstschg, en);
            tick(5);
            chk_bit(pme_oe, en);
            wr(PMCSR_OFS, pmcsr(2'(i), en, 1'b1));
            tick(1);
            chk_bit(pme_oe, 1'b0);
            // Link drop and return are both status changes
            @(posedge clk);
            link <= 1'b0;
            @(posedge clk);
            link <= 1'b1;
            tick(2);
            chk_bit(pme_oe, en);
            wr(PMCSR_OFS, pmcsr(2'(i), en, 1'b1));
            chk_bit(pme_oe, 1'b0);
        end
        wr(PMCSR_OFS, pmcsr(PS_D3, 1'b1, 1'b0));
        pulse_wake();
        u_host.pins(1'b0, 1'b1);
        tick(3);
        chk_bit(init, 1'b0);
        u_host.pins(1'b1, 1'b1);
        tick(1);
        chk_bit(init, 1'b1);
        tick(2);
        chk_state(state, d0_uninitialized);
        rd(PMCSR_OFS);
        chk_bit(rdata[PMCSR_PME_EN_BIT], 1'b1);
        chk_bit(rdata[PMCSR_PME_STS_BIT], 1'b1);
        chk_bit(pme_oe, 1'b1);
        wr(PMCSR_OFS, pmcsr(PS_D2, 1'b0, 1'b1));
        @(posedge clk);
        link <= 1'b0;
        tick(2);
        chk_bit(deep_pd, 1'b0);
        wr(PM_DRV_OFS, 16'h0001 << PM_DRV_DEEP_BIT);
        chk_bit(deep_pd, 1'b1);
        chk_bit(link_alive, 1'b0);
        rd(PM_DRV_OFS);
        chk_word(rdata, 16'h0001 << PM_DRV_DEEP_BIT);
        @(posedge clk);
        link <= 1'b1;
        tick(2);
        chk_bit(deep_pd, 1'b0);
        wr(PM_DRV_OFS, 16'h0000);
        wr(PMCSR_OFS, pmcsr(PS_D3, 1'b1, 1'b0));
        u_host.pins(1'b1, 1'b0);
        tick(2);
        chk_bit(bus_out_en, 1'b0);
        chk_bit(cfg_en, 1'b0);
        chk_bit(target_en, 1'b0);
        u_host.pins(1'b0, 1'b0);
        wr(PMCSR_OFS, pmcsr(PS_D1, 1'b1, 1'b0));
        u_host.pins(1'b1, 1'b0);
        tick(2);
        chk_bit(init, 1'b0);
        chk_state(state, st_d3);
        pulse_wake();
        chk_bit(pme_oe, strap);
        u_host.pins(1'b1, 1'b1);
        tick(1);
        chk_bit(init, 1'b1);
        tick(1);
        chk_state(state, d0_uninitialized);
        wr(PMCSR_OFS, pmcsr(PS_D0, 1'b0, 1'b1));
        wr(BAR_CTRL_OFS, 16'($urandom));
        strap = 1'($urandom);
        @(posedge clk);
        alt_n <= 1'b0;
        aux <= strap;
        tick(3);
        chk_bit(init, 1'b1);
        chk_state(state, d0_uninitialized);
        @(posedge clk);
        alt_n <= 1'b1;
        tick(3);
        aux <= ~strap;
        rd(PM_CAP_OFS);
        chk_word(rdata, exp_cap(strap));
        tally_and_finish();
    end
endmodule : pm_ctrl_tb
`default_nettype wire

// >>> verilog/init_gen.sv
`default_nettype none
module init_gen (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Reset sources
    input wire logic i_alternate_por_input_n,
    input wire logic i_bus_rst_n,
    input wire logic i_isolate_n,
    input wire logic i_in_d3,
    // Strap
    input wire logic i_aux_supply_sense,
    // Results
    output logic o_por,
    output logic o_init,
    output logic o_aux_strap
);
    import pm_pkg::*;

    typedef struct packed {
        logic por_win;
        logic iso_prev;
        logic rst_prev;
        logic aux;
        logic init;
    } gen_type;

    localparam gen_type GEN_RST = '{por_win: 1'b1, iso_prev: 1'b1,
        rst_prev: 1'b1, aux: 1'b0, init: 1'b1};

    gen_type r;
    gen_type n;

    always_comb begin
        n = r;
        n.por_win = ~i_alternate_por_input_n;
        if (r.por_win) begin
            n.aux = i_aux_supply_sense;
        end
        n.iso_prev = i_isolate_n;
        n.rst_prev = i_isolate_n ? i_bus_rst_n : 1'b1;
        n.init = r.por_win
            | (i_isolate_n & ~r.iso_prev)
            | (i_isolate_n & r.iso_prev & ~i_bus_rst_n & ~i_in_d3)
            | (i_isolate_n & r.iso_prev & i_bus_rst_n & ~r.rst_prev
               & i_in_d3);
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r <= GEN_RST;
        end else begin
            r <= n;
        end
    end

    assign o_por = r.por_win;
    assign o_init = r.init;
    assign o_aux_strap = r.aux;
endmodule : init_gen
`default_nettype wire

// >>> verilog/pm_ctrl.sv
// Contract
// - No bus mastering outside full power
// - Uninitialized substate after power-on reset
// - Uninitialized substate: target only, wake kept
// - Base address write activates device
// - Standby entered and left autonomously
// - D1: no master cycles, no interrupts
// - D1 keeps link alive, watches it
// - Wake event drives wake pins
// - D2 link down: deeper mode allowed
// - Driver register bit gates deeper mode
// - D3 like D2; no enable, link off
// - Cold D3 wakes only on auxiliary
// - Auxiliary strap shown in capability register
// - Alternate reset acts like power-on reset
// - Straps latched during power-on reset
// - Isolation ignores bus, floats outputs
// - Isolation release reinitializes device
// - Three sources raise internal initialization
// - Bus reset spares wake state if enabled
// - Wake reported only when enabled
`default_nettype none
module pm_ctrl #(
    parameter int IDLE_CYCLES = pm_pkg::STANDBY_IDLE_CYCLES
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Reset and power pins
    input wire logic i_alternate_por_input_n,
    input wire logic i_bus_rst_n,
    input wire logic i_isolate_n,
    input wire logic i_aux_supply_sense,
    // Configuration access
    input wire logic i_cfg_rd,
    input wire logic i_cfg_wr,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [15:0] i_cfg_wdata,
    output logic [15:0] o_cfg_rdata,
    // Link and activity
    input wire logic i_link_valid,
    input wire logic i_wake_pkt,
    input wire logic i_dev_busy,
    // Gating outputs
    output logic o_master_en,
    output logic o_target_en,
    output logic o_cfg_en,
    output logic o_irq_en,
    output logic o_bus_out_en,
    output logic o_wol_en,
    output logic o_link_alive,
    output logic o_deep_pd,
    output logic o_standby,
    output logic o_init,
    output pm_pkg::pm_state_type o_pm_state,
    // Wake pins
    output logic o_pme_n_oe,
    output logic o_cstschg
);
    import pm_pkg::*;

    typedef struct packed {
        pm_state_type st;
        logic bar_done;
        logic pme_en;
        logic deep_en;
        logic [15:0] rdata;
        logic [15:0] idle_cnt;
        logic standby;
    } ctrl_type;

    localparam ctrl_type CTRL_RST = '{st: d0_uninitialized, default: '0};
    localparam logic [15:0] IDLE_LAST = 16'(IDLE_CYCLES - 1);

    function automatic logic [1:0] ps_code(input pm_state_type s);
        case (s)
            st_d1: ps_code = PS_D1;
            st_d2: ps_code = PS_D2;
            st_d3: ps_code = PS_D3;
            default: ps_code = PS_D0;
        endcase
    endfunction : ps_code

    ctrl_type r;
    ctrl_type n;
    logic por;
    logic init;
    logic aux_strap;
    logic wake_sts;
    logic cfg_ok;
    logic pmcsr_wr;
    logic bar_wr;
    logic watch;
    logic low_d23;

    // ----------------------------------------
    // Reset sources and wake monitor
    // ----------------------------------------
    init_gen u_init (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_alternate_por_input_n(i_alternate_por_input_n),
        .i_bus_rst_n(i_bus_rst_n),
        .i_isolate_n(i_isolate_n),
        .i_in_d3(r.st == st_d3),
        .i_aux_supply_sense(i_aux_supply_sense),
        .o_por(por),
        .o_init(init),
        .o_aux_strap(aux_strap)
    );

    assign cfg_ok = i_isolate_n;
    assign pmcsr_wr = cfg_ok & i_cfg_wr & (i_cfg_addr == PMCSR_OFS);
    assign bar_wr = cfg_ok & i_cfg_wr & ((i_cfg_addr == BAR_CTRL_OFS)
        | (i_cfg_addr == BAR_IO_OFS) | (i_cfg_addr == BAR_MEM_OFS));
    assign watch = r.pme_en & (i_isolate_n | aux_strap);
    assign low_d23 = (r.st == st_d2) | (r.st == st_d3);

    wake_mon u_wake (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_clear_all(por | (init & ~r.pme_en)),
        .i_watch(watch),
        .i_pme_en(r.pme_en),
        .i_status_w1c(pmcsr_wr & i_cfg_wdata[PMCSR_PME_STS_BIT]),
        .i_link_valid(i_link_valid),
        .i_wake_pkt(i_wake_pkt),
        .o_status(wake_sts),
        .o_pme_n_oe(o_pme_n_oe),
        .o_cstschg(o_cstschg)
    );

    // ----------------------------------------
    // State and register update
    // ----------------------------------------
    always_comb begin
        n = r;
        if (r.st != d0_active_state || i_dev_busy) begin
            n.idle_cnt = '0;
            n.standby = 1'b0;
        end else if (r.idle_cnt == IDLE_LAST) begin
            n.standby = 1'b1;
        end else begin
            n.idle_cnt = r.idle_cnt + 16'h0001;
        end
        if (cfg_ok && i_cfg_rd) begin
            if (i_cfg_addr == PM_CAP_OFS) begin
                n.rdata = PM_CAP_BASE;
                n.rdata[PM_CAP_AUX_BIT] = aux_strap;
            end else if (i_cfg_addr == PMCSR_OFS) begin
                n.rdata = '0;
                n.rdata[PMCSR_STATE_LSB +: 2] = ps_code(r.st);
                n.rdata[PMCSR_PME_EN_BIT] = r.pme_en;
                n.rdata[PMCSR_PME_STS_BIT] = wake_sts;
            end else if (i_cfg_addr == PM_DRV_OFS) begin
                n.rdata = '0;
                n.rdata[PM_DRV_DEEP_BIT] = r.deep_en;
            end else begin
                n.rdata = '0;
            end
        end
        if (bar_wr) begin
            n.bar_done = 1'b1;
            if (r.st == d0_uninitialized) begin
                n.st = d0_active_state;
            end
        end else if (pmcsr_wr) begin
            n.pme_en = i_cfg_wdata[PMCSR_PME_EN_BIT];
            case (i_cfg_wdata[PMCSR_STATE_LSB +: 2])
                PS_D1: n.st = st_d1;
                PS_D2: n.st = st_d2;
                PS_D3: n.st = st_d3;
                default: begin
                    if (r.st == st_d1 || r.st == st_d2 || r.st == st_d3) begin
                        n.st = r.bar_done ? d0_active_state
                                          : d0_uninitialized;
                    end
                end
            endcase
        end else if (cfg_ok && i_cfg_wr && i_cfg_addr == PM_DRV_OFS) begin
            n.deep_en = i_cfg_wdata[PM_DRV_DEEP_BIT];
        end
        if (init) begin
            n.st = d0_uninitialized;
            n.bar_done = 1'b0;
            n.idle_cnt = '0;
            n.standby = 1'b0;
            // Wake settings survive when enabled
            if (!r.pme_en) begin
                n.pme_en = 1'b0;
                n.deep_en = 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst || por) begin
            r <= CTRL_RST;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // mastering and interrupts
    assign o_master_en = (r.st == d0_active_state) & i_isolate_n;
    assign o_irq_en = (r.st == d0_active_state) & i_isolate_n;
    assign o_target_en = ((r.st == d0_active_state)
        | (r.st == d0_uninitialized)) & i_isolate_n;
    assign o_cfg_en = cfg_ok;
    assign o_wol_en = (r.st == d0_uninitialized);
    assign o_bus_out_en = i_isolate_n;
    assign o_deep_pd = low_d23 & r.deep_en & ~i_link_valid;
    assign o_link_alive = ~o_deep_pd & ((r.st != st_d3) | r.pme_en);
    assign o_standby = r.standby;
    assign o_init = init;
    assign o_pm_state = r.st;
    assign o_cfg_rdata = r.rdata;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_no_master;
        @(posedge i_clk) disable iff (i_sys_rst)
        (r.st != d0_active_state) |-> !o_master_en && !o_irq_en;
    endproperty
    a_no_master: assert property (p_no_master)
        else $error("master or irq enabled outside active state");

    property p_por_uninit;
        @(posedge i_clk) disable iff (i_sys_rst)
        por |=> (o_pm_state == d0_uninitialized) && !o_master_en;
    endproperty
    a_por_uninit: assert property (p_por_uninit)
        else $error("not uninitialized after power-on reset");

    property p_bar_activate;
        @(posedge i_clk) disable iff (i_sys_rst)
        (r.st == d0_uninitialized && bar_wr && !init && !por)
        |=> o_master_en || !i_isolate_n;
    endproperty
    a_bar_activate: assert property (p_bar_activate)
        else $error("base address write did not activate");

    property p_state_write;
        @(posedge i_clk) disable iff (i_sys_rst)
        (pmcsr_wr && i_cfg_wdata[1:0] == PS_D1 && !init && !por)
        |=> (o_pm_state == st_d1) ##1 (o_pm_state == st_d1 || $past(init));
    endproperty
    a_state_write: assert property (p_state_write)
        else $error("power state write not applied");

    property p_d1_alive;
        @(posedge i_clk) disable iff (i_sys_rst)
        (r.st == st_d1) |-> o_link_alive && !o_deep_pd;
    endproperty
    a_d1_alive: assert property (p_d1_alive)
        else $error("link dropped in D1");

    property p_d3_off;
        @(posedge i_clk) disable iff (i_sys_rst)
        (r.st == st_d3 && !r.pme_en) |-> !o_link_alive && !watch;
    endproperty
    a_d3_off: assert property (p_d3_off)
        else $error("D3 without enable keeps link or wake");

    property p_deep_gate;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_deep_pd |-> r.deep_en && low_d23 && !i_link_valid;
    endproperty
    a_deep_gate: assert property (p_deep_gate)
        else $error("deep mode without permission");

    property p_isolate;
        @(posedge i_clk) disable iff (i_sys_rst)
        !i_isolate_n |-> !o_bus_out_en && !o_target_en && !o_cfg_en;
    endproperty
    a_isolate: assert property (p_isolate)
        else $error("bus driven while isolated");

    property p_iso_release;
        @(posedge i_clk) disable iff (i_sys_rst)
        $rose(i_isolate_n) |=> init ##1 (o_pm_state == d0_uninitialized);
    endproperty
    a_iso_release: assert property (p_iso_release)
        else $error("no init after isolation release");

    property p_pme_drive;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wake_sts && r.pme_en && !por && !init && !pmcsr_wr)
        |=> o_pme_n_oe && o_cstschg;
    endproperty
    a_pme_drive: assert property (p_pme_drive)
        else $error("wake status not driven on pins");

    property p_standby;
        @(posedge i_clk) disable iff (i_sys_rst)
        (r.st != d0_active_state || i_dev_busy) |=> !o_standby;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby held while busy or not active");
endmodule : pm_ctrl
`default_nettype wire

// >>> verilog/pm_pkg.sv
`default_nettype none
package pm_pkg;
    // ----------------------------------------
    // Configuration space offsets
    // ----------------------------------------
    localparam logic [7:0] PM_CAP_OFS = 8'hde;
    localparam logic [7:0] PMCSR_OFS = 8'he0;
    localparam logic [7:0] PM_DRV_OFS = 8'he4;
    localparam logic [7:0] BAR_CTRL_OFS = 8'h10;
    localparam logic [7:0] BAR_IO_OFS = 8'h14;
    localparam logic [7:0] BAR_MEM_OFS = 8'h18;
    // ----------------------------------------
    // Field positions and values
    // ----------------------------------------
    localparam int PMCSR_STATE_LSB = 0;
    localparam int PMCSR_PME_EN_BIT = 8;
    localparam int PMCSR_PME_STS_BIT = 15;
    localparam int PM_CAP_AUX_BIT = 15;
    localparam int PM_DRV_DEEP_BIT = 0;
    localparam logic [15:0] PM_CAP_BASE = 16'h0022;
    localparam logic [1:0] PS_D0 = 2'h0;
    localparam logic [1:0] PS_D1 = 2'h1;
    localparam logic [1:0] PS_D2 = 2'h2;
    localparam logic [1:0] PS_D3 = 2'h3;
    localparam int STANDBY_IDLE_CYCLES = 64;
    // ----------------------------------------
    // Power states
    // ----------------------------------------
    typedef enum logic [2:0] {
        d0_uninitialized,
        d0_active_state,
        st_d1,
        st_d2,
        st_d3
    } pm_state_type;
endpackage : pm_pkg
`default_nettype wire

// >>> verilog/wake_mon.sv
`default_nettype none
module wake_mon (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_sys_rst,
    // Control
    input wire logic i_clear_all,
    input wire logic i_watch,
    input wire logic i_pme_en,
    input wire logic i_status_w1c,
    // Link events
    input wire logic i_link_valid,
    input wire logic i_wake_pkt,
    // Indications
    output logic o_status,
    output logic o_pme_n_oe,
    output logic o_cstschg
);
    import pm_pkg::*;

    typedef struct packed {
        logic link_prev;
        logic status;
        logic drive;
    } wake_type;

    localparam wake_type WAKE_RST = '{default: 1'b0};

    wake_type r;
    wake_type n;
    logic event_hit;

    always_comb begin
        n = r;
        event_hit = i_watch & (i_wake_pkt | (i_link_valid ^ r.link_prev));
        n.link_prev = i_link_valid;
        if (i_clear_all) begin
            n.status = 1'b0;
        end else if (event_hit) begin
            // Set beats a same-cycle write-one-to-clear, but not i_clear_all
            n.status = 1'b1;
        end else if (i_status_w1c) begin
            n.status = 1'b0;
        end
        n.drive = n.status & i_pme_en;
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            r <= WAKE_RST;
        end else begin
            r <= n;
        end
    end

    assign o_status = r.status;
    assign o_pme_n_oe = r.drive;
    assign o_cstschg = r.drive;
endmodule : wake_mon
`default_nettype wire
